//--- hdl/acs_pkg.sv
// Package: constants and types for the conversion sequencer
package acs_pkg;
    // Register word offsets
    localparam logic [3:0] ACS_REG_CTRL = 4'h0;
    localparam logic [3:0] ACS_REG_CLKSEL = 4'h1;
    localparam logic [3:0] ACS_REG_TRIG = 4'h2;
    localparam logic [3:0] ACS_REG_RES_HI = 4'h3;
    localparam logic [3:0] ACS_REG_RES_LO = 4'h4;
    localparam logic [3:0] ACS_REG_STAT = 4'h5;
    localparam logic [3:0] ACS_REG_MASK = 4'h6;
    localparam logic [3:0] ACS_REG_SLEEP = 4'h7;
    // Control field positions
    localparam int ACS_CTRL_ON = 0;
    localparam int ACS_CTRL_GO = 1;
    // Status bit positions
    localparam int ACS_STAT_DONE = 0;
    // Sleep register bit
    localparam int ACS_SLEEP_REQ = 0;
    // Reset values
    localparam logic [7:0] ACS_RST_BYTE = 8'h00;
    localparam logic [2:0] ACS_RST_CLKSEL = 3'h0;
    localparam logic [3:0] ACS_RST_TRIG = 4'h0;
    // Trigger source codes
    localparam logic [3:0] ACS_TRIG_OFF = 4'h0;
    localparam logic [3:0] ACS_TRIG_PIN = 4'h1;
    localparam int ACS_TRIG_SRC_W = 19;
    // Result width and timing
    localparam int ACS_RES_W = 10;
    localparam int ACS_DIV_W = 7;
    // RC oscillator bit period in ns (nominal) and its count at 25 MHz
    localparam int ACS_CLK_NS = 40;
    localparam int ACS_RC_PERIOD_NS = 2000;
    localparam int ACS_RC_DIV = (ACS_RC_PERIOD_NS + ACS_CLK_NS - 1) / ACS_CLK_NS;
    // Instruction cycle: four system clocks
    localparam int ACS_INSTR_CYC = 4;
    localparam logic [3:0] ACS_SAR_LAST = 4'h0;

    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_DELAY,
        ACS_CONV
    } acs_state_e;
endpackage

//--- hdl/acs_clkdiv.sv
// Conversion bit-period enable generator
`timescale 1ns/1ps
`default_nettype none
module acs_clkdiv
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [ACS_DIV_W-1:0] cnt_q;
    logic [ACS_DIV_W-1:0] div;

    // Codes 000, 100, 001, 101, 010, 110 map to /2, /4, /8, /16, /32, /64; x11 selects the RC source
    always_comb begin
        if (sel[1:0] == 2'b11) begin
            div = ACS_DIV_W'(ACS_RC_DIV);
        end else begin
            div = ACS_DIV_W'(2) << {sel[1:0], sel[2]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q >= div - ACS_DIV_W'(1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + ACS_DIV_W'(1);
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- hdl/acs_top.sv
// Conversion sequencer: registers, start/abort control, SAR stepping
`timescale 1ns/1ps
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic trigger_pin_route,
    input wire logic [ACS_TRIG_SRC_W-1:0] periph_trig,
    input wire logic comp_in,
    output logic dac_bit_en,
    output logic [ACS_RES_W-1:0] dac_code,
    output logic analog_power,
    output logic wake_up,
    output logic irq
);
    import acs_pkg::*;

    // ==========================================================
    // Registers and state
    // ==========================================================
    logic converter_on_q;
    logic go_q;
    logic [2:0] conv_clock_select_q;
    logic [3:0] auto_trigger_select_q;
    logic [7:0] result_high_q;
    logic [7:0] result_low_q;
    logic conv_done_flag_q;
    logic mask_q;
    logic sleeping_q;
    logic powered_down_q;
    logic trig_prev_q;
    acs_state_e state_q;
    logic [3:0] bit_q;
    logic [ACS_RES_W-1:0] sar_q;
    logic [1:0] dly_q;
    logic last_bit_q;

    logic wr_ctrl;
    logic sw_go;
    logic sw_abort;
    logic trig_sel;
    logic trig_rise;
    logic start_req;
    logic tick;
    logic is_rc;
    logic finish;
    logic sleep_abort;
    logic done_evt;
    logic rd_stat;

    function automatic logic [ACS_RES_W-1:0] fill_partial(
        input logic [ACS_RES_W-1:0] v,
        input logic [3:0] pos,
        input logic last
    );
        logic [ACS_RES_W-1:0] r;
        r = v;
        for (int i = 0; i < ACS_RES_W; i++) begin
            if (i < int'(pos)) begin
                r[i] = last;
            end
        end
        return r;
    endfunction

    assign is_rc = (conv_clock_select_q[1:0] == 2'b11);
    assign wr_ctrl = wr && (addr == ACS_REG_CTRL);
    assign rd_stat = rd && (addr == ACS_REG_STAT);

    // ==========================================================
    // Trigger source selection
    // ==========================================================
    always_comb begin
        if (auto_trigger_select_q == ACS_TRIG_OFF) begin
            trig_sel = 1'b0;
        end else if (auto_trigger_select_q == ACS_TRIG_PIN) begin
            trig_sel = trigger_pin_route;
        end else begin
            trig_sel = periph_trig[auto_trigger_select_q];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_sel;
        end
    end

    assign trig_rise = trig_sel && !trig_prev_q;
    // Enable must already be set; a write that turns on and sets go is not a start
    assign sw_go = wr_ctrl && wdata[ACS_CTRL_GO] && wdata[ACS_CTRL_ON] && converter_on_q;
    assign sw_abort = wr_ctrl && !wdata[ACS_CTRL_GO] && go_q;
    assign start_req = !go_q && converter_on_q && !powered_down_q
                       && (sw_go || trig_rise);
    assign sleep_abort = wr && (addr == ACS_REG_SLEEP) && wdata[ACS_SLEEP_REQ]
                         && !is_rc && go_q;
    assign finish = (state_q == ACS_CONV) && tick && (bit_q == ACS_SAR_LAST);
    assign done_evt = finish;

    // ==========================================================
    // Bit-period divider
    // ==========================================================
    acs_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .run(state_q == ACS_CONV),
        .sel(conv_clock_select_q),
        .tick(tick)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ACS_IDLE;
            go_q <= 1'b0;
            bit_q <= 4'h0;
            sar_q <= '0;
            dly_q <= 2'h0;
            last_bit_q <= 1'b0;
        end else begin
            case (state_q)
                ACS_IDLE: begin
                    if (start_req) begin
                        go_q <= 1'b1;
                        bit_q <= 4'(ACS_RES_W - 1);
                        sar_q <= '0;
                        last_bit_q <= 1'b0;
                        // RC source waits one more instruction for a sleep
                        dly_q <= 2'(ACS_INSTR_CYC - 1);
                        state_q <= is_rc ? ACS_DELAY : ACS_CONV;
                    end
                end
                ACS_DELAY: begin
                    if (sw_abort) begin
                        go_q <= 1'b0;
                        state_q <= ACS_IDLE;
                    end else if (dly_q == 2'h0) begin
                        state_q <= ACS_CONV;
                    end else begin
                        dly_q <= dly_q - 2'h1;
                    end
                end
                ACS_CONV: begin
                    if (sw_abort || sleep_abort) begin
                        go_q <= 1'b0;
                        state_q <= ACS_IDLE;
                    end else if (tick) begin
                        sar_q[bit_q] <= comp_in;
                        last_bit_q <= comp_in;
                        if (bit_q == ACS_SAR_LAST) begin
                            go_q <= 1'b0;
                            state_q <= ACS_IDLE;
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                default: begin
                    state_q <= ACS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Result registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            result_high_q <= ACS_RST_BYTE;
            result_low_q <= ACS_RST_BYTE;
        end else if (finish) begin
            result_high_q <= sar_q[9:2];
            result_low_q <= {sar_q[1:0], 6'h00};
            if (bit_q == ACS_SAR_LAST) begin
                result_low_q <= {sar_q[1], comp_in, 6'h00};
            end
        end else if (state_q == ACS_CONV && sw_abort) begin
            // Bits above bit_q are converted; fill the rest with the last one
            {result_high_q, result_low_q[7:6]} <=
                fill_partial(sar_q, bit_q + 4'h1, last_bit_q);
            result_low_q[5:0] <= 6'h00;
        end
    end

    // ==========================================================
    // Control and configuration registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            converter_on_q <= 1'b0;
            conv_clock_select_q <= ACS_RST_CLKSEL;
            auto_trigger_select_q <= ACS_RST_TRIG;
            mask_q <= 1'b0;
        end else if (wr) begin
            if (addr == ACS_REG_CTRL) begin
                converter_on_q <= wdata[ACS_CTRL_ON];
            end else if (addr == ACS_REG_CLKSEL) begin
                conv_clock_select_q <= wdata[2:0];
            end else if (addr == ACS_REG_TRIG) begin
                auto_trigger_select_q <= wdata[3:0];
            end else if (addr == ACS_REG_MASK) begin
                mask_q <= wdata[ACS_STAT_DONE];
            end
        end
    end

    // ==========================================================
    // Sleep, power and wake-up
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            sleeping_q <= 1'b0;
            powered_down_q <= 1'b0;
            wake_up <= 1'b0;
        end else begin
            wake_up <= 1'b0;
            if (wr && addr == ACS_REG_SLEEP) begin
                sleeping_q <= wdata[ACS_SLEEP_REQ];
                if (wdata[ACS_SLEEP_REQ] && !is_rc) begin
                    powered_down_q <= 1'b1;
                end else if (!wdata[ACS_SLEEP_REQ]) begin
                    powered_down_q <= 1'b0;
                end
            end else if (done_evt && sleeping_q) begin
                if (mask_q) begin
                    wake_up <= 1'b1;
                    sleeping_q <= 1'b0;
                end else begin
                    powered_down_q <= 1'b1;
                end
            end
            if (wr_ctrl && !wdata[ACS_CTRL_ON]) begin
                powered_down_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Done flag, interrupt and analog outputs
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            conv_done_flag_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Set wins over the read-clear
            if (done_evt) begin
                conv_done_flag_q <= 1'b1;
            end else if (rd_stat) begin
                conv_done_flag_q <= 1'b0;
            end
            irq <= (done_evt || (conv_done_flag_q && !rd_stat)) && mask_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            analog_power <= 1'b0;
            dac_bit_en <= 1'b0;
            dac_code <= '0;
        end else begin
            analog_power <= converter_on_q && !powered_down_q;
            dac_bit_en <= (state_q == ACS_CONV);
            dac_code <= sar_q | (ACS_RES_W'(1) << bit_q);
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (!rd) begin
            rdata <= 8'h00;
        end else if (addr == ACS_REG_CTRL) begin
            rdata <= {6'h00, go_q, converter_on_q};
        end else if (addr == ACS_REG_CLKSEL) begin
            rdata <= {5'h00, conv_clock_select_q};
        end else if (addr == ACS_REG_TRIG) begin
            rdata <= {4'h0, auto_trigger_select_q};
        end else if (addr == ACS_REG_RES_HI) begin
            rdata <= result_high_q;
        end else if (addr == ACS_REG_RES_LO) begin
            rdata <= result_low_q;
        end else if (addr == ACS_REG_STAT) begin
            rdata <= {7'h00, conv_done_flag_q};
        end else if (addr == ACS_REG_MASK) begin
            rdata <= {7'h00, mask_q};
        end else if (addr == ACS_REG_SLEEP) begin
            rdata <= {7'h00, sleeping_q};
        end else begin
            rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_done_clears_go: assert property (@(posedge clk) disable iff (rst)
        finish |=> !go_q && conv_done_flag_q) else $error("go not cleared on done");
    a_off_no_start: assert property (@(posedge clk) disable iff (rst)
        (!converter_on_q && !go_q) |=> !go_q) else $error("start while off");
    a_trig_sets_go: assert property (@(posedge clk) disable iff (rst)
        (trig_rise && state_q == ACS_IDLE && converter_on_q && !powered_down_q)
        |=> go_q) else $error("trigger did not start");
    a_rc_delay: assert property (@(posedge clk) disable iff (rst)
        (start_req && is_rc && state_q == ACS_IDLE)
        |=> (state_q == ACS_DELAY) [*4]) else $error("rc delay wrong");
    a_abort_stops: assert property (@(posedge clk) disable iff (rst)
        (state_q == ACS_CONV && sw_abort) |=> state_q == ACS_IDLE && !go_q)
        else $error("abort ignored");
    a_sleep_abort: assert property (@(posedge clk) disable iff (rst)
        sleep_abort |=> !go_q && converter_on_q ##1 !analog_power)
        else $error("sleep abort wrong");
    a_wake_event: assert property (@(posedge clk) disable iff (rst)
        (done_evt && sleeping_q && mask_q && !wr) |=> wake_up)
        else $error("no wake-up");
    a_off_in_sleep: assert property (@(posedge clk) disable iff (rst)
        (done_evt && sleeping_q && !mask_q && !wr) |=> ##1 !analog_power && converter_on_q)
        else $error("converter not powered down");
endmodule
`default_nettype wire

//--- verif/acs_afe_model.sv
// Analog front end model: comparator against a held input level
`timescale 1ns/1ps
`default_nettype none
module acs_afe_model
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic [ACS_RES_W-1:0] vin,
    input wire logic [ACS_RES_W-1:0] dac_code,
    input wire logic dac_bit_en,
    output logic comp_in
);
    logic junk_q = 1'b0;
    // Decision is meaningless outside a conversion, so it wobbles
    always @(posedge clk) junk_q <= ~junk_q;
    assign comp_in = dac_bit_en ? (vin >= dac_code) : junk_q;
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import acs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pin = 1'b0;
    logic [ACS_TRIG_SRC_W-1:0] ptrig = '0;
    logic [ACS_RES_W-1:0] vin = '0;
    logic [7:0] rdata;
    logic [7:0] r;
    logic comp_in;
    logic dac_bit_en;
    logic analog_power;
    logic wake_up;
    logic irq;
    logic [ACS_RES_W-1:0] dac_code;
    int fail_count = 0;
    int cmp_count = 0;
    int wake_cnt = 0;
    int cyc;
    logic [2:0] sel_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
    int div_tab [7] = '{2, 4, 8, 16, 32, 64, ACS_RC_DIV};
    logic [9:0] vin_tab [7] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA, 10'h001, 10'h200, 10'h1C7};
    logic [9:0] abort_tab [2] = '{10'h300, 10'h0FF};

    acs_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trigger_pin_route(pin), .periph_trig(ptrig), .comp_in(comp_in),
        .dac_bit_en(dac_bit_en), .dac_code(dac_code), .analog_power(analog_power),
        .wake_up(wake_up), .irq(irq));
    acs_afe_model afe (.clk(clk), .vin(vin), .dac_code(dac_code), .dac_bit_en(dac_bit_en),
        .comp_in(comp_in));

    always #20 clk = ~clk;
    always @(posedge clk) if (wake_up === 1'b1) wake_cnt <= wake_cnt + 1;

    // ========================================
    // Tasks
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = rdata;
    endtask
    task automatic wait_done(input int lim);
        cyc = 0;
        do begin
            rd_reg(ACS_REG_CTRL);
            cyc += 2;
        end while (r[ACS_CTRL_GO] === 1'b1 && cyc < lim);
        chk(r[ACS_CTRL_GO], 1'b0);
    endtask
    task automatic chk_res(input logic [9:0] v);
        rd_reg(ACS_REG_RES_HI);
        chk(r, v[9:2]);
        rd_reg(ACS_REG_RES_LO);
        chk(r, {v[1:0], 6'h00});
    endtask
    // Switch-on and go are separate writes
    task automatic start(input logic [2:0] sel, input logic [9:0] v);
        vin <= v;
        wr_reg(ACS_REG_CLKSEL, {5'h00, sel});
        wr_reg(ACS_REG_CTRL, 8'h01);
        wr_reg(ACS_REG_CTRL, 8'h03);
    endtask

    // ========================================
    // Main sequence
    initial begin
        int dly;
        int w0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_reg(a[3:0]);
            chk(r, 8'h00);
        end
        wr_reg(4'h9, 8'hFF);
        rd_reg(4'h9);
        chk(r, 8'h00);
        wr_reg(ACS_REG_MASK, 8'h01);
        for (int i = 0; i < 7; i++) begin
            dly = (i == 6) ? ACS_INSTR_CYC : 0;
            start(sel_tab[i], vin_tab[i]);
            wait_done(2000);
            chk(cyc >= 9 * div_tab[i] + dly, 1'b1);
            chk(cyc <= 10 * div_tab[i] + dly + 16, 1'b1);
            chk_res(vin_tab[i]);
            chk(irq, 1'b1);
            rd_reg(ACS_REG_STAT);
            chk(r, 8'h01);
            @(posedge clk);
            #1;
            chk(irq, 1'b0);
        end
        // Abort mid-way: both patterns hold for three to nine converted bits
        for (int i = 0; i < 2; i++) begin
            start(3'h6, abort_tab[i]);
            repeat (320) @(posedge clk);
            wr_reg(ACS_REG_CTRL, 8'h01);
            rd_reg(ACS_REG_CTRL);
            chk(r, 8'h01);
            chk_res(abort_tab[i]);
        end
        rd_reg(ACS_REG_STAT);
        wr_reg(ACS_REG_MASK, 8'h00);
        wr_reg(ACS_REG_CLKSEL, 8'h00);
        vin <= 10'h2D3;
        // Unselected sources rise first and must be ignored
        for (int n = 0; n < 16; n++) begin
            @(posedge clk);
            ptrig <= '0;
            pin <= 1'b0;
            wr_reg(ACS_REG_TRIG, {4'h0, n[3:0]});
            ptrig <= ~(ACS_TRIG_SRC_W'(1) << n);
            pin <= (n != 1);
            repeat (6) @(posedge clk);
            rd_reg(ACS_REG_CTRL);
            chk(r, 8'h01);
            if (n == 0) continue;
            ptrig <= '1;
            pin <= 1'b1;
            wait_done(200);
            chk(cyc >= 18, 1'b1);
            chk_res(10'h2D3);
        end
        rd_reg(ACS_REG_STAT);
        chk(r, 8'h01);
        chk(irq, 1'b0);
        wr_reg(ACS_REG_TRIG, 8'h01);
        pin <= 1'b0;
        wr_reg(ACS_REG_CTRL, 8'h02);
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        rd_reg(ACS_REG_CTRL);
        chk(r, 8'h00);
        wr_reg(ACS_REG_CTRL, 8'h03);
        rd_reg(ACS_REG_CTRL);
        chk(r, 8'h01);
        wr_reg(ACS_REG_TRIG, 8'h00);
        // Sleep entered inside the start delay of the RC source
        wr_reg(ACS_REG_MASK, 8'h01);
        w0 = wake_cnt;
        start(3'h3, 10'h26B);
        wr_reg(ACS_REG_SLEEP, 8'h01);
        wait_done(2000);
        chk_res(10'h26B);
        chk(16'(wake_cnt - w0), 16'h0001);
        wr_reg(ACS_REG_SLEEP, 8'h00);
        rd_reg(ACS_REG_STAT);
        wr_reg(ACS_REG_MASK, 8'h00);
        start(3'h7, 10'h0C4);
        wr_reg(ACS_REG_SLEEP, 8'h01);
        wait_done(2000);
        chk_res(10'h0C4);
        chk(analog_power, 1'b0);
        rd_reg(ACS_REG_CTRL);
        chk(r, 8'h01);
        chk(16'(wake_cnt - w0), 16'h0001);
        chk(irq, 1'b0);
        wr_reg(ACS_REG_SLEEP, 8'h00);
        @(posedge clk);
        #1;
        chk(analog_power, 1'b1);
        start(3'h6, 10'h155);
        repeat (100) @(posedge clk);
        wr_reg(ACS_REG_SLEEP, 8'h01);
        repeat (3) @(posedge clk);
        rd_reg(ACS_REG_CTRL);
        chk(r, 8'h01);
        chk({analog_power, dac_bit_en}, 2'h0);
        wr_reg(ACS_REG_SLEEP, 8'h00);
        // Reset in mid-conversion with the done flag still set
        start(3'h6, 10'h155);
        repeat (100) @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({analog_power, dac_bit_en, irq}, 3'h0);
        for (int a = 0; a < 8; a++) begin
            rd_reg(a[3:0]);
            chk(r, 8'h00);
        end
        end_of_test();
    end

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
